/* File: rtl/upcs_defs.svh */
`ifndef UPCS_DEFS_SVH
`define UPCS_DEFS_SVH
// Clock rate in kHz, used to turn times into cycle counts.
`define UPCS_CLK_KHZ 250000
// Discharge pulse time in ms.
`define UPCS_DISCHARGE_PULSE_MS 350
`define UPCS_DISCHARGE_PULSE_CYC (`UPCS_DISCHARGE_PULSE_MS * `UPCS_CLK_KHZ)
// Overcurrent deglitch in ms.
`define UPCS_OC_DEGLITCH_MS 9
`define UPCS_OC_DEGLITCH_CYC (`UPCS_OC_DEGLITCH_MS * `UPCS_CLK_KHZ)
// Charging flag release deglitch in ms.
`define UPCS_CHG_DEGLITCH_MS 9
`define UPCS_CHG_DEGLITCH_CYC (`UPCS_CHG_DEGLITCH_MS * `UPCS_CLK_KHZ)
// Thermal fault release delay in ms.
`define UPCS_OT_RELEASE_MS 9
`define UPCS_OT_RELEASE_CYC (`UPCS_OT_RELEASE_MS * `UPCS_CLK_KHZ)
// Auto-detect return to divider after detach, in s.
`define UPCS_DETACH_TIMEOUT_S 10
// Unsigned product, since this count lies beyond the signed 32-bit range.
`define UPCS_DETACH_TIMEOUT_CYC (`UPCS_DETACH_TIMEOUT_S * 32'h3E8 * `UPCS_CLK_KHZ)
`endif

/* File: rtl/upcs_pkg.sv */
package upcs_pkg;
  // Mode select codes on the three control pins.
  typedef enum logic [2:0] {
    UPCS_MODE_OFF      = 3'h0,
    UPCS_MODE_AUTO     = 3'h1,
    UPCS_MODE_SDP_WAKE = 3'h2,
    UPCS_MODE_CDP_WAKE = 3'h3,
    UPCS_MODE_SHORTED  = 3'h4,
    UPCS_MODE_DIVIDER  = 3'h5,
    UPCS_MODE_SDP      = 3'h6,
    UPCS_MODE_CDP      = 3'h7
  } upcs_mode_t;

  // Charger emulation profile applied to the data lines.
  typedef enum logic [1:0] {
    UPCS_PROF_NONE     = 2'h0,
    UPCS_PROF_DATA     = 2'h1,
    UPCS_PROF_DIVIDER  = 2'h2,
    UPCS_PROF_SHORTED  = 2'h3
  } upcs_prof_t;

  // Discharge sequencer states, Gray along idle, pulse, apply.
  typedef enum logic [1:0] {
    UPCS_SEQ_IDLE  = 2'h0,
    UPCS_SEQ_PULSE = 2'h1,
    UPCS_SEQ_APPLY = 2'h3
  } upcs_seq_t;
endpackage

/* File: rtl/upcs_tmr_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Start condition and done flag between the supervisor and one timer.
interface upcs_tmr_if;
  logic run;
  logic done;
  modport owner (output run, input done);
  modport timer (input run, output done);
endinterface
`default_nettype wire

/* File: rtl/upcs_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Counts while run is high and restarts whenever run drops.
module upcs_timer #(
  parameter int unsigned COUNT = 16
) (
  // Clock and reset.
  input  wire logic     clock_in,
  input  wire logic     rst_b_in,
  // Run and done.
  upcs_tmr_if.timer     tmr
);
  import upcs_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        done;
  } upcs_tmr_st_t;

  upcs_tmr_st_t st;
  upcs_tmr_st_t next_st;

  // Done rises once COUNT cycles of continuous run have passed.
  always_comb begin
    next_st = st;
    if (!tmr.run) begin
      next_st.cnt  = 32'h0;
      next_st.done = 1'b0;
    end else if (st.cnt < COUNT - 1) begin
      next_st.cnt = st.cnt + 32'h1;
    end else begin
      next_st.done = 1'b1;
    end
  end

  // Synchronous reset clears the count.
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tmr.done = st.done;
endmodule
`default_nettype wire

/* File: rtl/upcs_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Mode change discharges output for 350 ms.
// - Wakeup transitions skip pulse, keep data switch.
// - Permanent discharge when disabled or mode 000.
// - Charging flag low above 20 mA threshold.
// - CDP flags only after handshake precedes current.
// - Charging flag releases after full deglitch below.
// - Switch off above 150 C, on after cooling.
// - Undervoltage lockout disables the whole circuit.
// - Fault flag low during overcurrent or overtemperature.
// - Overcurrent reported after 9 ms deglitch.
// - Overtemperature fault immediate, released after delay.
// - Enable low turns switches and profiles off.
// - Disabled clears both flags to high impedance.
// - Mode code map; host moves bits together.
// - Auto-detect: divider, shorted on negotiation, 10 s back.
`include "upcs_defs.svh"
module upcs_supervisor #(
  parameter int unsigned DISCHARGE_CYC = `UPCS_DISCHARGE_PULSE_CYC,
  parameter int unsigned OC_DEGLITCH_CYC = `UPCS_OC_DEGLITCH_CYC,
  parameter int unsigned CHG_DEGLITCH_CYC = `UPCS_CHG_DEGLITCH_CYC,
  parameter int unsigned OT_RELEASE_CYC = `UPCS_OT_RELEASE_CYC,
  parameter int unsigned DETACH_CYC = `UPCS_DETACH_TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire logic               clock_in,
  input  wire logic               rst_b_in,
  // Host pins.
  input  wire logic               enable_in,
  input  wire logic [2:0]         mode_select_pins_in,
  // Analog comparators.
  input  wire logic               undervoltage_lockout_in,
  input  wire logic               over_temp_in,
  input  wire logic               over_current_in,
  input  wire logic               above_charge_thr_in,
  input  wire logic               cdp_handshake_done_in,
  input  wire logic               negotiation_seen_in,
  input  wire logic               device_attached_in,
  // Power path controls.
  output logic                    power_switch_on_out,
  output logic                    data_switch_on_out,
  output logic                    discharge_on_out,
  output upcs_pkg::upcs_prof_t    profile_out,
  // Open-drain flags, enable high while pulling low.
  output logic                    charging_oe_out,
  output logic                    charging_o_out,
  output logic                    fault_oe_out,
  output logic                    fault_o_out
);
  import upcs_pkg::*;

  typedef struct packed {
    logic [1:0] en_s;
    logic [5:0] mode_s;
    logic [1:0] uv_s;
    logic [1:0] ot_s;
    logic [1:0] oc_s;
    logic [1:0] chg_s;
    logic [1:0] hs_s;
    logic [1:0] neg_s;
    logic [1:0] att_s;
    upcs_seq_t  seq;
    upcs_mode_t applied;
    logic       auto_shorted;
    logic       hs_first;
    logic       chg_flag;
    logic       fault_flag;
    logic       ot_latched;
    logic       pwr;
    logic       data;
    logic       dis;
    upcs_prof_t prof;
  } upcs_sup_st_t;

  upcs_sup_st_t st;
  upcs_sup_st_t next_st;

  upcs_tmr_if t_dis ();
  upcs_tmr_if t_oc ();
  upcs_tmr_if t_chg ();
  upcs_tmr_if t_ot ();
  upcs_tmr_if t_det ();

  // Synchronised views: second stage of each two-flop chain only.
  logic       en;
  logic       uv;
  logic       ot;
  logic       oc;
  logic       chg;
  logic       hs;
  logic       neg;
  logic       att;
  upcs_mode_t mode;
  logic       active;
  logic       wake_pair;

  assign en     = st.en_s[1];
  assign uv     = st.uv_s[1];
  assign ot     = st.ot_s[1];
  assign oc     = st.oc_s[1];
  assign chg    = st.chg_s[1];
  assign hs     = st.hs_s[1];
  assign neg    = st.neg_s[1];
  assign att    = st.att_s[1];
  assign mode   = upcs_mode_t'(st.mode_s[5:3]);
  assign active = en && !uv;

  // A change between x10 or 111 and 011 keeps the port alive for remote wakeup.
  assign wake_pair = (mode != st.applied) &&
                     (((mode == UPCS_MODE_CDP_WAKE) &&
                       ((st.applied == UPCS_MODE_SDP) || (st.applied == UPCS_MODE_SDP_WAKE) ||
                        (st.applied == UPCS_MODE_CDP))) ||
                      ((st.applied == UPCS_MODE_CDP_WAKE) &&
                       ((mode == UPCS_MODE_SDP) || (mode == UPCS_MODE_SDP_WAKE) ||
                        (mode == UPCS_MODE_CDP))));

  // Timers restart as soon as their qualifying condition goes away.
  assign t_dis.run = (st.seq == UPCS_SEQ_PULSE);
  assign t_oc.run  = active && oc;
  assign t_chg.run = active && !chg;
  assign t_ot.run  = active && !ot && st.ot_latched;
  assign t_det.run = active && (mode == UPCS_MODE_AUTO) && st.auto_shorted && !att;

  upcs_timer #(.COUNT(DISCHARGE_CYC)) u_dis (.clock_in(clock_in), .rst_b_in(rst_b_in), .tmr(t_dis));
  upcs_timer #(.COUNT(OC_DEGLITCH_CYC)) u_oc (.clock_in(clock_in), .rst_b_in(rst_b_in), .tmr(t_oc));
  upcs_timer #(.COUNT(CHG_DEGLITCH_CYC)) u_chg (.clock_in(clock_in), .rst_b_in(rst_b_in), .tmr(t_chg));
  upcs_timer #(.COUNT(OT_RELEASE_CYC)) u_ot (.clock_in(clock_in), .rst_b_in(rst_b_in), .tmr(t_ot));
  upcs_timer #(.COUNT(DETACH_CYC)) u_det (.clock_in(clock_in), .rst_b_in(rst_b_in), .tmr(t_det));

  // Next state: synchronisers, discharge sequencer, flags and power path.
  always_comb begin
    next_st        = st;
    next_st.en_s   = {st.en_s[0], enable_in};
    next_st.mode_s = {st.mode_s[2:0], mode_select_pins_in};
    next_st.uv_s   = {st.uv_s[0], undervoltage_lockout_in};
    next_st.ot_s   = {st.ot_s[0], over_temp_in};
    next_st.oc_s   = {st.oc_s[0], over_current_in};
    next_st.chg_s  = {st.chg_s[0], above_charge_thr_in};
    next_st.hs_s   = {st.hs_s[0], cdp_handshake_done_in};
    next_st.neg_s  = {st.neg_s[0], negotiation_seen_in};
    next_st.att_s  = {st.att_s[0], device_attached_in};

    // Sequencer for the discharge pulse on mode changes.
    unique case (st.seq)
      UPCS_SEQ_IDLE: begin
        if (!active) begin
          next_st.applied = UPCS_MODE_OFF;
        end else if (wake_pair) begin
          next_st.applied = mode;
        end else if (mode != st.applied) begin
          next_st.seq = UPCS_SEQ_PULSE;
        end else if ((mode == UPCS_MODE_AUTO) && !st.auto_shorted && neg) begin
          next_st.seq = UPCS_SEQ_PULSE;
        end
      end
      UPCS_SEQ_PULSE: begin
        if (!active) begin
          next_st.seq = UPCS_SEQ_IDLE;
        end else if (t_dis.done) begin
          next_st.seq = UPCS_SEQ_APPLY;
        end
      end
      UPCS_SEQ_APPLY: begin
        next_st.seq = UPCS_SEQ_IDLE;
        if ((mode == UPCS_MODE_AUTO) && (st.applied == UPCS_MODE_AUTO)) begin
          next_st.auto_shorted = 1'b1;
        end else begin
          next_st.auto_shorted = 1'b0;
        end
        next_st.applied = mode;
      end
      default: begin
        next_st.seq = UPCS_SEQ_IDLE;
      end
    endcase
    if (t_det.done || !active) begin
      next_st.auto_shorted = 1'b0;
    end

    // Thermal latch: trips at once, clears after the cooled release delay.
    if (!active) begin
      next_st.ot_latched = 1'b0;
    end else if (ot) begin
      next_st.ot_latched = 1'b1;
    end else if (t_ot.done) begin
      next_st.ot_latched = 1'b0;
    end

    // Fault: overcurrent after deglitch, overtemperature immediately.
    next_st.fault_flag = active && ((oc && t_oc.done) || ot || st.ot_latched);

    // CDP handshake must precede the current crossing the threshold.
    if (!active || (st.applied != UPCS_MODE_CDP) || !hs) begin
      next_st.hs_first = 1'b0;
    end else if (!chg) begin
      next_st.hs_first = 1'b1;
    end

    // Charging flag in CDP and DCP modes; release after full deglitch, or at once when inactive or out of idle.
    if (!active || (st.seq != UPCS_SEQ_IDLE)) begin
      next_st.chg_flag = 1'b0;
    end else if (chg && ((st.applied == UPCS_MODE_AUTO) || (st.applied == UPCS_MODE_DIVIDER) ||
                         (st.applied == UPCS_MODE_SHORTED) ||
                         ((st.applied == UPCS_MODE_CDP) && st.hs_first))) begin
      next_st.chg_flag = 1'b1;
    end else if (t_chg.done) begin
      next_st.chg_flag = 1'b0;
    end

    // Power path follows the applied mode and protection state.
    // The switch returns as soon as the die has cooled; the fault flag lags behind it on purpose.
    next_st.dis  = !active || (mode == UPCS_MODE_OFF) || (st.seq == UPCS_SEQ_PULSE);
    next_st.pwr  = active && !next_st.dis && !ot;
    next_st.data = active && (st.seq == UPCS_SEQ_IDLE) &&
                   ((st.applied == UPCS_MODE_SDP) || (st.applied == UPCS_MODE_SDP_WAKE) ||
                    (st.applied == UPCS_MODE_CDP) || (st.applied == UPCS_MODE_CDP_WAKE));
    if (!active || (st.seq != UPCS_SEQ_IDLE)) begin
      next_st.prof = UPCS_PROF_NONE;
    end else begin
      unique case (st.applied)
        UPCS_MODE_OFF: next_st.prof = UPCS_PROF_NONE;
        UPCS_MODE_AUTO: next_st.prof = st.auto_shorted ? UPCS_PROF_SHORTED : UPCS_PROF_DIVIDER;
        UPCS_MODE_DIVIDER: next_st.prof = UPCS_PROF_DIVIDER;
        UPCS_MODE_SHORTED: next_st.prof = UPCS_PROF_SHORTED;
        UPCS_MODE_SDP, UPCS_MODE_SDP_WAKE, UPCS_MODE_CDP, UPCS_MODE_CDP_WAKE: next_st.prof = UPCS_PROF_DATA;
      endcase
    end
  end

  // Reset leaves the port off and discharged.
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      st     <= '0;
      st.dis <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign power_switch_on_out = st.pwr;
  assign data_switch_on_out  = st.data;
  assign discharge_on_out    = st.dis;
  assign profile_out         = st.prof;
  assign charging_oe_out     = st.chg_flag;
  assign charging_o_out      = 1'b0;
  assign fault_oe_out        = st.fault_flag;
  assign fault_o_out         = 1'b0;

  // Checks on the power path, the flags and the wakeup exception.
  chk_disabled_flags_clear: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !en |-> ##1 (!charging_oe_out && !fault_oe_out))
    else $error("flags not cleared while disabled");
  chk_disabled_discharge: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (!en || mode == UPCS_MODE_OFF) |-> ##1 discharge_on_out)
    else $error("discharge off while disabled or mode off");
  chk_disabled_switch_off: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !active |-> ##1 (!power_switch_on_out && !data_switch_on_out))
    else $error("switches on while inactive");
  chk_hot_switch_off: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ot |-> ##1 !power_switch_on_out)
    else $error("power switch on while hot");
  chk_hot_fault_now: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (active && ot) |-> ##1 fault_oe_out)
    else $error("overtemperature fault not immediate");
  chk_oc_glitch_quiet: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (active && !ot && !st.ot_latched && $rose(oc)) |-> ##1 !fault_oe_out)
    else $error("overcurrent reported without deglitch");
  chk_pulse_discharges: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (st.seq == UPCS_SEQ_PULSE) |-> ##1 (discharge_on_out && !power_switch_on_out))
    else $error("no discharge during pulse");
  chk_wake_no_pulse: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (active && st.seq == UPCS_SEQ_IDLE && wake_pair) |=> (st.seq == UPCS_SEQ_IDLE))
    else $error("pulse on wakeup transition");
  chk_chg_hold: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (active && st.seq == UPCS_SEQ_IDLE && charging_oe_out && $fell(chg)) |=> charging_oe_out)
    else $error("charging flag released without deglitch");
  chk_uv_lock: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    uv |-> ##1 !power_switch_on_out)
    else $error("switch on under lockout");
  chk_wake_keeps_data: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (active && st.seq == UPCS_SEQ_IDLE && wake_pair) |=> (data_switch_on_out && !discharge_on_out))
    else $error("data switch dropped on wakeup transition");
  chk_fault_needs_cause: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (!oc && !ot && !st.ot_latched) |=> !fault_oe_out)
    else $error("fault shown with no condition");
  chk_cdp_needs_handshake: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (!charging_oe_out && st.applied == UPCS_MODE_CDP && !st.hs_first) |=> !charging_oe_out)
    else $error("charging flag in CDP without prior handshake");

  // Main scenarios that a run should reach.
  cov_mode_pulse: cover property (@(posedge clock_in) disable iff (!rst_b_in)
    st.seq == UPCS_SEQ_PULSE ##1 st.seq == UPCS_SEQ_APPLY);
  cov_wake: cover property (@(posedge clock_in) disable iff (!rst_b_in) active && wake_pair);
  cov_fault: cover property (@(posedge clock_in) disable iff (!rst_b_in) $rose(fault_oe_out));
  cov_charge: cover property (@(posedge clock_in) disable iff (!rst_b_in) $rose(charging_oe_out));
  cov_auto_shorted: cover property (@(posedge clock_in) disable iff (!rst_b_in) $rose(st.auto_shorted));
endmodule
`default_nettype wire

/* File: testbench/upcs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host controller model: drives enable and mode pins and watches the fault pin.
module upcs_host_model (
  // Clock.
  input  wire logic       clock_in,
  // Requests from the bench.
  input  wire logic       want_enable_in,
  input  wire logic [2:0] want_mode_in,
  input  wire logic       drop_on_fault_in,
  // Fault pin level, low while a fault is shown.
  input  wire logic       fault_pin_in,
  // Pins toward the device.
  output logic            enable_out,
  output logic [2:0]      mode_out
);
  logic tripped;
  wire logic trip_now = drop_on_fault_in && !fault_pin_in;

  // The trip is latched, since the flag clears once disabled and would bounce enable.
  always @(posedge clock_in) begin
    tripped    <= #1 want_enable_in && (tripped || trip_now);
    enable_out <= #1 want_enable_in && !(tripped || trip_now);
    mode_out   <= #1 want_mode_in;
  end
endmodule
`default_nettype wire

/* File: testbench/tb_usb_port_charge_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_usb_port_charge_supervisor;
  import upcs_pkg::*;
  localparam int DIS = 20;
  localparam int OC  = 8;
  localparam int CHG = 8;
  localparam int OT  = 8;
  localparam int DET = 30;
  typedef struct packed {logic en; logic [2:0] mode; logic [7:0] exp;} upcs_row_t;
  logic       clock_in, rst_b_in, want_en, drop_fault, undervoltage_lockout, ot, oc, thr, hs, neg, att;
  logic [2:0] want_mode, mode_pins;
  logic       en_pin, pwr, dsw, dis, ch_oe, ch_o, f_oe, f_o;
  upcs_prof_t prof;
  int         errors, n_checks, cyc, k, lost;
  upcs_row_t  rows [10];
  logic [2:0] wake [6];
  // The fault pin has a pull-up, so it reads high when nobody pulls it.
  wire logic       fault_pin = f_oe ? f_o : 1'b1;
  wire logic [7:0] st        = {1'b0, f_oe, ch_oe, pwr, dsw, dis, prof};

  upcs_host_model HOST (.clock_in(clock_in), .want_enable_in(want_en), .want_mode_in(want_mode),
    .drop_on_fault_in(drop_fault), .fault_pin_in(fault_pin), .enable_out(en_pin), .mode_out(mode_pins));

  upcs_supervisor #(.DISCHARGE_CYC(DIS), .OC_DEGLITCH_CYC(OC), .CHG_DEGLITCH_CYC(CHG),
    .OT_RELEASE_CYC(OT), .DETACH_CYC(DET)) DUT (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .enable_in(en_pin), .mode_select_pins_in(mode_pins), .undervoltage_lockout_in(undervoltage_lockout),
    .over_temp_in(ot), .over_current_in(oc), .above_charge_thr_in(thr), .cdp_handshake_done_in(hs),
    .negotiation_seen_in(neg), .device_attached_in(att), .power_switch_on_out(pwr),
    .data_switch_on_out(dsw), .discharge_on_out(dis), .profile_out(prof), .charging_oe_out(ch_oe),
    .charging_o_out(ch_o), .fault_oe_out(f_oe), .fault_o_out(f_o));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs always move one nanosecond after the rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // Counts discharge cycles and cycles with the data switch off.
  task automatic watch(input int n);
    k    = 0;
    lost = 0;
    repeat (n) begin
      tick(1);
      k    += int'(dis === 1'b1);
      lost += int'(dsw !== 1'b1);
    end
  endtask

  task automatic report_and_stop;
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    {rst_b_in, want_en, drop_fault, undervoltage_lockout, ot, oc, thr, hs, neg, att} = '0;
    want_mode = 3'h0;
    rows = '{'{1, 3'h6, 8'h19}, '{1, 3'h7, 8'h19}, '{1, 3'h0, 8'h04}, '{1, 3'h5, 8'h12},
             '{1, 3'h4, 8'h13}, '{1, 3'h1, 8'h12}, '{1, 3'h2, 8'h19}, '{1, 3'h3, 8'h19},
             '{0, 3'h6, 8'h04}, '{0, 3'h1, 8'h04}};
    wake = '{3'h3, 3'h2, 3'h3, 3'h7, 3'h3, 3'h6};
    tick(8);
    rst_b_in = 1'b1;
    // Steady state of every mode code enabled, and of codes 110 and 001 disabled.
    foreach (rows[i]) begin
      want_en   = rows[i].en;
      want_mode = rows[i].mode;
      tick(45);
      check(st, rows[i].exp);
    end
    // A plain mode change gives one discharge pulse of the set length.
    want_en   = 1'b1;
    want_mode = 3'h6;
    tick(45);
    want_mode = 3'h5;
    tick(8);
    check({dis, pwr}, 2'b10);
    watch(60);
    // Four pulse cycles pass before the watch starts; the pulse spans the count plus its exit cycle.
    check(k >= DIS - 4 && k <= DIS - 2, 1'b1);
    // Wakeup transitions keep the data switch on with no pulse.
    want_mode = 3'h6;
    tick(45);
    foreach (wake[i]) begin
      want_mode = wake[i];
      watch(20);
      check({|k, |lost}, 2'b00);
    end
    // Charging flag in a dedicated charging mode, with a short dip that must not release it.
    want_mode = 3'h5;
    tick(45);
    thr = 1'b1;
    tick(6);
    check({ch_oe, ch_o}, 2'b10);
    thr = 1'b0;
    tick(4);
    thr = 1'b1;
    tick(CHG + 6);
    check(ch_oe, 1'b1);
    thr = 1'b0;
    tick(CHG);
    check(ch_oe, 1'b1);
    tick(8);
    check(ch_oe, 1'b0);
    // Charging downstream mode flags only when the handshake came first.
    want_mode = 3'h7;
    tick(45);
    thr = 1'b1;
    tick(CHG + 10);
    check(ch_oe, 1'b0);
    thr = 1'b0;
    hs  = 1'b1;
    tick(CHG + 10);
    thr = 1'b1;
    tick(6);
    check(ch_oe, 1'b1);
    {thr, hs} = 2'b00;
    tick(CHG + 10);
    // A short overcurrent is ignored; a held one is shown until it goes.
    oc = 1'b1;
    tick(5);
    oc = 1'b0;
    tick(OC + 8);
    check(f_oe, 1'b0);
    oc = 1'b1;
    tick(OC);
    check(f_oe, 1'b0);
    tick(8);
    check({f_oe, f_o}, 2'b10);
    oc = 1'b0;
    tick(6);
    check(f_oe, 1'b0);
    // Overtemperature trips at once and is released after cooling.
    ot = 1'b1;
    tick(5);
    check({f_oe, pwr}, 2'b10);
    ot = 1'b0;
    tick(OT);
    check({f_oe, pwr}, 2'b11);
    tick(8);
    check(f_oe, 1'b0);
    // Undervoltage holds everything off.
    undervoltage_lockout = 1'b1;
    tick(6);
    check({pwr, dsw, prof}, 4'h0);
    undervoltage_lockout = 1'b0;
    tick(45);
    check(st, 8'h19);
    // Auto mode moves to shorted lines after a negotiation and back once detached.
    want_mode = 3'h1;
    att       = 1'b1;
    tick(45);
    neg = 1'b1;
    tick(2);
    neg = 1'b0;
    watch(60);
    check({k >= DIS, prof}, {1'b1, UPCS_PROF_SHORTED});
    att = 1'b0;
    tick(DET - 10);
    check(prof, UPCS_PROF_SHORTED);
    tick(40);
    check(prof, UPCS_PROF_DIVIDER);
    // The host drops enable on a fault, which clears both flags.
    want_mode  = 3'h5;
    drop_fault = 1'b1;
    thr        = 1'b1;
    tick(45);
    oc = 1'b1;
    tick(OC + 20);
    check({en_pin, f_oe, ch_oe, pwr, dsw, dis}, 6'h01);
    {oc, thr, drop_fault, want_en} = 4'h0;
    tick(2);
    want_en = 1'b1;
    tick(45);
    check(st, 8'h12);
    // A second reset in mid-run returns to the reset state.
    rst_b_in = 1'b0;
    tick(2);
    check(st, 8'h04);
    rst_b_in = 1'b1;
    tick(2);
    check(st, 8'h04);
    report_and_stop();
  end
endmodule
`default_nettype wire
